// ---- rtl/sfp_pin_if.sv ----
// Purpose: device-side pin logic of a serial flash host interface
// Assumes: master uses clock modes 0 or 3; the serial clock is the link clock
// Notes:   link logic runs on the serial clock; the user side runs on clk_sys
`timescale 1ns/100ps
`include "sfp_defs.svh"

module sfp_pin_if
	import sfp_pkg::*;
#(
	parameter int BYTE_W = `SFP_BYTE_W
) (
	input  wire logic              clk_sys,
	input  wire logic              reset,
	input  wire logic              cs_n,
	input  wire logic              sck,
	input  wire logic              hold_n,
	input  wire logic              wp_n,
	input  wire logic              dual_lane_low_in,
	output logic                   dual_lane_low_out,
	output logic                   dual_lane_low_oe,
	output logic                   dual_lane_high_out,
	output logic                   dual_lane_high_oe,
	output logic      [BYTE_W-1:0] rx_data,
	output logic                   rx_valid,
	input  wire logic [BYTE_W-1:0] tx_data,
	input  wire logic              tx_dual,
	input  wire logic              tx_valid,
	output logic                   tx_ready,
	input  wire logic              busy,
	output logic                   frame_active,
	output logic                   hold_paused,
	output logic                   standby,
	output logic                   wp_lock
);

	////////////////////////////////////////////////////////////////////////////
	// Link side: capture on rising serial clock edges
	////////////////////////////////////////////////////////////////////////////
	// Frame reset: deselect or system reset clears the bit position
	logic frame_rst;
	logic link_rst;
	assign frame_rst = cs_n | reset;
	assign link_rst  = reset;
	logic [BYTE_W-1:0]     rx_shift_reg;
	logic [BYTE_W-1:0]     rx_shift_next;
	logic [`SFP_CNT_W-1:0] rx_cnt_reg;
	logic [`SFP_CNT_W-1:0] rx_cnt_next;
	logic [BYTE_W-1:0]     rx_word_reg;
	logic [BYTE_W-1:0]     rx_word_next;
	logic                  rx_toggle_reg;
	logic                  rx_toggle_next;
	// Output-side state read by the capture logic
	logic                  out_en_reg;
	logic                  dual_reg;
	// Capture one bit per rising edge unless held or driving the low lane
	always_comb begin
		rx_shift_next  = rx_shift_reg;
		rx_cnt_next    = rx_cnt_reg;
		rx_word_next   = rx_word_reg;
		rx_toggle_next = rx_toggle_reg;
		if (hold_n && !(out_en_reg && dual_reg)) begin
			rx_shift_next = {rx_shift_reg[BYTE_W-2:0], dual_lane_low_in};
			rx_cnt_next   = rx_cnt_reg + `SFP_CNT_ONE;
			if (rx_cnt_reg == `SFP_SINGLE_LAST) begin
				rx_word_next   = {rx_shift_reg[BYTE_W-2:0], dual_lane_low_in};
				rx_toggle_next = ~rx_toggle_reg;
			end
		end
	end

	// Bit position and partial byte are cleared by deselect or system reset
	always_ff @(posedge sck or posedge frame_rst) begin
		if (frame_rst) begin
			rx_shift_reg <= `SFP_BYTE_ZERO;
			rx_cnt_reg   <= `SFP_CNT_ZERO;
		end else begin
			rx_shift_reg <= rx_shift_next;
			rx_cnt_reg   <= rx_cnt_next;
		end
	end

	// Completed byte and its toggle survive deselect so no event is lost
	always_ff @(posedge sck or posedge link_rst) begin
		if (link_rst) begin
			rx_word_reg   <= `SFP_BYTE_ZERO;
			rx_toggle_reg <= 1'b0;
		end else begin
			rx_word_reg   <= rx_word_next;
			rx_toggle_reg <= rx_toggle_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Link side: drive on falling serial clock edges
	////////////////////////////////////////////////////////////////////////////
	logic [BYTE_W-1:0]     tx_hold_reg;
	logic                  tx_hold_dual_reg;
	logic                  tx_req_reg;
	logic                  req_meta_reg;
	logic                  req_sync_reg;
	logic                  tx_ack_reg;
	logic                  req_meta_next;
	logic                  req_sync_next;
	logic                  tx_ack_next;
	logic [BYTE_W-1:0]     tx_shift_reg;
	logic [BYTE_W-1:0]     tx_shift_next;
	logic [`SFP_CNT_W-1:0] tx_cnt_reg;
	logic [`SFP_CNT_W-1:0] tx_cnt_next;
	logic                  out_en_next;
	logic                  dual_next;
	logic                  hi_bit_reg;
	logic                  hi_bit_next;
	logic                  lo_bit_reg;
	logic                  lo_bit_next;
	logic                  load_byte;
	// Word crossing: toggle is synchronised, data is stable until acked;
	// a byte loads only selected and at a byte boundary of the exchange
	always_comb begin
		req_meta_next = tx_req_reg;
		req_sync_next = req_meta_reg;
		load_byte     = !cs_n && hold_n && (tx_cnt_reg == `SFP_CNT_ZERO) &&
			(rx_cnt_reg == `SFP_CNT_ZERO) && (req_sync_reg != tx_ack_reg);
		tx_ack_next   = load_byte ? ~tx_ack_reg : tx_ack_reg;
	end

	// Handshake registers are not touched by deselect
	always_ff @(negedge sck or posedge link_rst) begin
		if (link_rst) begin
			req_meta_reg <= 1'b0;
			req_sync_reg <= 1'b0;
			tx_ack_reg   <= 1'b0;
		end else begin
			req_meta_reg <= req_meta_next;
			req_sync_reg <= req_sync_next;
			tx_ack_reg   <= tx_ack_next;
		end
	end

	// Shift out one or two bits per falling edge; idle lane when nothing queued
	always_comb begin
		tx_shift_next = tx_shift_reg;
		tx_cnt_next   = tx_cnt_reg;
		out_en_next   = out_en_reg;
		dual_next     = dual_reg;
		hi_bit_next   = hi_bit_reg;
		lo_bit_next   = lo_bit_reg;
		if (hold_n) begin
			if (tx_cnt_reg == `SFP_CNT_ZERO) begin
				if (load_byte) begin
					out_en_next = 1'b1;
					dual_next   = tx_hold_dual_reg;
					hi_bit_next = tx_hold_reg[BYTE_W-1];
					lo_bit_next = tx_hold_reg[BYTE_W-2];
					tx_cnt_next = `SFP_CNT_ONE;
					tx_shift_next = tx_hold_dual_reg ? {tx_hold_reg[BYTE_W-3:0], 2'b00} :
						{tx_hold_reg[BYTE_W-2:0], 1'b0};
				end else begin
					out_en_next = 1'b0;
				end
			end else begin
				hi_bit_next = tx_shift_reg[BYTE_W-1];
				lo_bit_next = tx_shift_reg[BYTE_W-2];
				if (dual_reg) begin
					tx_shift_next = {tx_shift_reg[BYTE_W-3:0], 2'b00};
					tx_cnt_next   = (tx_cnt_reg == `SFP_DUAL_LAST) ?
						`SFP_CNT_ZERO : tx_cnt_reg + `SFP_CNT_ONE;
				end else begin
					tx_shift_next = {tx_shift_reg[BYTE_W-2:0], 1'b0};
					tx_cnt_next   = (tx_cnt_reg == `SFP_SINGLE_LAST) ?
						`SFP_CNT_ZERO : tx_cnt_reg + `SFP_CNT_ONE;
				end
			end
		end
	end

	// Output shifter: a new frame always starts from an idle, released lane
	always_ff @(negedge sck or posedge frame_rst) begin
		if (frame_rst) begin
			tx_shift_reg <= `SFP_BYTE_ZERO;
			tx_cnt_reg   <= `SFP_CNT_ZERO;
			out_en_reg   <= 1'b0;
			dual_reg     <= 1'b0;
			hi_bit_reg   <= 1'b0;
			lo_bit_reg   <= 1'b0;
		end else begin
			tx_shift_reg <= tx_shift_next;
			tx_cnt_reg   <= tx_cnt_next;
			out_en_reg   <= out_en_next;
			dual_reg     <= dual_next;
			hi_bit_reg   <= hi_bit_next;
			lo_bit_reg   <= lo_bit_next;
		end
	end

	// Enables react to the pins at once, not at the next clock edge
	assign dual_lane_high_out = hi_bit_reg;
	assign dual_lane_low_out  = lo_bit_reg;
	assign dual_lane_high_oe  = !cs_n && hold_n && out_en_reg;
	assign dual_lane_low_oe   = !cs_n && hold_n && out_en_reg && dual_reg;

	////////////////////////////////////////////////////////////////////////////
	// System side: synchronisers
	////////////////////////////////////////////////////////////////////////////
	logic [`SFP_SYNC_W-1:0] sync_in;
	logic [`SFP_SYNC_W-1:0] sync_out;
	logic                   cs_n_s;
	logic                   hold_n_s;
	logic                   wp_n_s;
	logic                   rx_toggle_s;
	logic                   tx_ack_s;
	// Pins idle high, toggles idle low
	assign sync_in = {cs_n, hold_n, wp_n, rx_toggle_reg, tx_ack_reg};

	sfp_sync #(
		.WIDTH     (`SFP_SYNC_W),
		.RESET_VAL (`SFP_SYNC_RST)
	) u_sync (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.async_in (sync_in),
		.sync_out (sync_out)
	);
	assign {cs_n_s, hold_n_s, wp_n_s, rx_toggle_s, tx_ack_s} = sync_out;

	////////////////////////////////////////////////////////////////////////////
	// System side: byte delivery and response queueing
	////////////////////////////////////////////////////////////////////////////
	logic                  rx_seen_reg;
	logic                  rx_seen_next;
	logic [BYTE_W-1:0]     rx_data_reg;
	logic [BYTE_W-1:0]     rx_data_next;
	logic                  rx_valid_reg;
	logic                  rx_valid_next;
	logic [BYTE_W-1:0]     tx_hold_next;
	logic                  tx_hold_dual_next;
	logic                  tx_req_next;
	// Ready while the link has acknowledged the last queued byte
	assign tx_ready = (tx_req_reg == tx_ack_s);

	// Latch received bytes; queue one response byte at a time
	always_comb begin
		rx_seen_next      = rx_toggle_s;
		rx_valid_next     = (rx_toggle_s != rx_seen_reg);
		rx_data_next      = rx_data_reg;
		tx_hold_next      = tx_hold_reg;
		tx_hold_dual_next = tx_hold_dual_reg;
		tx_req_next       = tx_req_reg;
		if (rx_toggle_s != rx_seen_reg) begin
			rx_data_next = rx_word_reg;
		end
		if (tx_valid && tx_ready) begin
			tx_hold_next      = tx_data;
			tx_hold_dual_next = tx_dual;
			tx_req_next       = ~tx_req_reg;
		end
	end

	// Received word is stable for a whole byte time after its toggle flips, so it is read here without a synchroniser
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rx_seen_reg      <= 1'b0;
			rx_valid_reg     <= 1'b0;
			rx_data_reg      <= `SFP_BYTE_ZERO;
			tx_hold_reg      <= `SFP_BYTE_ZERO;
			tx_hold_dual_reg <= 1'b0;
			tx_req_reg       <= 1'b0;
		end else begin
			rx_seen_reg      <= rx_seen_next;
			rx_valid_reg     <= rx_valid_next;
			rx_data_reg      <= rx_data_next;
			tx_hold_reg      <= tx_hold_next;
			tx_hold_dual_reg <= tx_hold_dual_next;
			tx_req_reg       <= tx_req_next;
		end
	end

	assign rx_data  = rx_data_reg;
	assign rx_valid = rx_valid_reg;

	////////////////////////////////////////////////////////////////////////////
	// System side: frame state, standby and write protect
	////////////////////////////////////////////////////////////////////////////
	sfp_frame_type frame_reg;
	sfp_frame_type frame_next;
	logic          standby_reg;
	logic          standby_next;
	logic          wp_lock_reg;
	logic          wp_lock_next;
	// Hold pauses only the exchange; busy is never gated by it
	always_comb begin
		frame_next   = frame_reg;
		standby_next = cs_n_s && !busy;
		wp_lock_next = !wp_n_s;
		case (frame_reg)
			SFP_DESELECTED: begin
				if (!cs_n_s) begin
					frame_next = SFP_ACTIVE;
				end
			end
			SFP_ACTIVE: begin
				if (cs_n_s) begin
					frame_next = SFP_DESELECTED;
				end else if (!hold_n_s) begin
					frame_next = SFP_PAUSED;
				end
			end
			SFP_PAUSED: begin
				if (cs_n_s) begin
					frame_next = SFP_DESELECTED;
				end else if (hold_n_s) begin
					frame_next = SFP_ACTIVE;
				end
			end
			default: begin
				frame_next = SFP_DESELECTED;
			end
		endcase
	end

	// Status registers; the pad pull-up keeps a floating hold high
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			frame_reg   <= SFP_DESELECTED;
			standby_reg <= 1'b0;
			wp_lock_reg <= 1'b0;
		end else begin
			frame_reg   <= frame_next;
			standby_reg <= standby_next;
			wp_lock_reg <= wp_lock_next;
		end
	end

	assign frame_active = (frame_reg != SFP_DESELECTED);
	assign hold_paused  = (frame_reg == SFP_PAUSED);
	assign standby      = standby_reg;
	assign wp_lock      = wp_lock_reg;

endmodule : sfp_pin_if

// ---- pkg/sfp_defs.svh ----
// Purpose: constants for the serial flash pin interface
// Assumes: one byte per serial word, most significant bit first
// Notes:   shared by the pin interface and synchroniser modules
// Function
// - While chip select is high, serial input values are ignored.
// - Response data changes on the serial output only at serial clock falling edges.
// - In dual read, output is high lane; input pin is low lane; two bits per edge.
// - Serial output is high impedance whenever chip select is high.
// - Hold only pauses the exchange; no deselect, no command state reset.
// - During hold, clock and input are ignored and output is high impedance.
// - Hold may begin only with chip select low and serial clock low.
// - Hold never pauses or alters a running self-timed program or erase cycle.
// - Low write protect input drives hardware locking of protected regions.
// - An unconnected hold input reads as deasserted.
// - Operations start on chip select fall, end on rise; standby waits for busy.
// - Command, address and write data are captured on serial clock rising edges.
`ifndef SFP_DEFS_SVH
`define SFP_DEFS_SVH

`define SFP_BYTE_W       8
`define SFP_CNT_W        3
`define SFP_CNT_ZERO     3'h0
`define SFP_CNT_ONE      3'h1
`define SFP_SINGLE_LAST  3'h7
`define SFP_DUAL_LAST    3'h3
`define SFP_BYTE_ZERO    8'h00
`define SFP_SYNC_W       5
`define SFP_SYNC_RST     5'h1C

`endif

// ---- pkg/sfp_pkg.sv ----
// Purpose: types for the serial flash pin interface
// Assumes: constants come from sfp_defs.svh
// Notes:   no timing figures live here
package sfp_pkg;

	// Lane mode of one response byte
	typedef enum logic {
		SFP_LANE_SINGLE,
		SFP_LANE_DUAL
	} sfp_lane_type;

	// Frame state as seen from the system clock
	typedef enum logic [1:0] {
		SFP_DESELECTED,
		SFP_ACTIVE,
		SFP_PAUSED
	} sfp_frame_type;

endpackage : sfp_pkg

// ---- rtl/sfp_sync.sv ----
// Purpose: two-stage synchroniser for a vector of independent levels
// Assumes: each bit is a level or a toggle, never a multi-bit word
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
`include "sfp_defs.svh"

module sfp_sync
	import sfp_pkg::*;
#(
	parameter int              WIDTH     = `SFP_SYNC_W,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input  wire logic             clk_sys,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] sync_next;

	// Next values: stage one takes the pin, stage two takes stage one
	always_comb begin
		meta_next = async_in;
		sync_next = meta_reg;
	end

	// Both stages return to the idle level on reset
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			meta_reg <= RESET_VAL;
			sync_reg <= RESET_VAL;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign sync_out = sync_reg;

endmodule : sfp_sync

// ---- testbench/sfp_pin_if_assertions.sv ----
// Purpose: port-level checks of sfp_pin_if
// Assumes: link clock idles low outside frames
// Notes:   status outputs lag their pins by up to four system cycles
`timescale 1ns/100ps
module sfp_pin_if_checker (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic hold_n,
	input wire logic wp_n,
	input wire logic dual_lane_low_out,
	input wire logic dual_lane_low_oe,
	input wire logic dual_lane_high_out,
	input wire logic dual_lane_high_oe,
	input wire logic rx_valid,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic busy,
	input wire logic frame_active,
	input wire logic hold_paused,
	input wire logic standby,
	input wire logic wp_lock
);
	////////////////////////////////////////
	// Lane drivers follow the pins at once
	desel_off_a: assert property (@(posedge clk_sys) disable iff (reset)
		cs_n |-> !dual_lane_high_oe) else $error("high lane driven while deselected");
	hold_off_a: assert property (@(posedge clk_sys) disable iff (reset)
		!hold_n |-> !dual_lane_high_oe && !dual_lane_low_oe) else $error("lane driven in hold");
	low_pair_a: assert property (@(posedge clk_sys) disable iff (reset)
		dual_lane_low_oe |-> dual_lane_high_oe) else $error("low lane driven alone");
	// A change seen across a high phase means data moved on a rising edge
	high_edge_a: assert property (@(sck) disable iff (reset)
		sck |-> $stable(dual_lane_high_out)) else $error("high lane moved off a falling edge");
	low_edge_a: assert property (@(sck) disable iff (reset)
		sck |-> $stable(dual_lane_low_out)) else $error("low lane moved off a falling edge");
	// Status flags: five cycles cover the synchroniser
	frame_a: assert property (@(posedge clk_sys) disable iff (reset)
		!cs_n [*5] |-> frame_active) else $error("frame flag missing");
	pause_a: assert property (@(posedge clk_sys) disable iff (reset)
		(!cs_n && !hold_n) [*5] |-> hold_paused && frame_active) else $error("pause flag missing");
	busy_wait_a: assert property (@(posedge clk_sys) disable iff (reset)
		busy [*5] |-> !standby) else $error("standby while busy");
	wp_lock_a: assert property (@(posedge clk_sys) disable iff (reset)
		!wp_n [*5] |-> wp_lock) else $error("lock missing");
	rx_pulse_a: assert property (@(posedge clk_sys) disable iff (reset)
		rx_valid |=> !rx_valid) else $error("receive strobe too long");
	tx_take_a: assert property (@(posedge clk_sys) disable iff (reset)
		tx_valid && tx_ready |=> !tx_ready) else $error("byte not taken");
endmodule : sfp_pin_if_checker

bind sfp_pin_if sfp_pin_if_checker chk (.*);

// ---- testbench/sfp_host_model.sv ----
// Purpose: mode 0 host model driving the flash pins
// Assumes: 125 ns link period, clock low while idle
// Notes:   the clock also runs while deselected, to show input rejection
`timescale 1ns/100ps
module sfp_host_model (
	output logic      cs_n,
	output logic      sck,
	output logic      hold_low,
	output logic      si_drv,
	input  wire logic so_line,
	input  wire logic si_line
);
	////////////////////////////////////////
	// Idle pins: deselected, clock low, hold released
	initial begin
		cs_n     = 1'h1;
		sck      = 1'h0;
		hold_low = 1'h0;
		si_drv   = 1'h0;
	end
	// Frame edges with the clock low, so no stray edge is seen
	task automatic frame_start();
		#30 cs_n = 1'h0;
		#62.5;
	endtask : frame_start
	task automatic frame_end();
		#62.5 cs_n = 1'h1;
		#125;
	endtask : frame_end
	// One clock: data set after the fall, both lanes sampled at the rise
	task automatic clk_bit(input logic d, output logic hi, output logic lo);
		si_drv = d;
		#62.5 sck = 1'h1;
		hi = so_line;
		lo = si_line;
		#62.5 sck = 1'h0;
	endtask : clk_bit
	// Byte: eight single clocks, or four in dual read
	task automatic xfer(input logic [7:0] tx, input logic dual, output logic [7:0] rx);
		logic hi;
		logic lo;
		for (int i = 7; i >= 0; i--) begin
			if (!dual) begin
				clk_bit(tx[i], hi, lo);
				rx[i] = hi;
			end else if (i[0]) begin
				clk_bit(~si_drv, hi, lo);
				rx[i] = hi;
				rx[i - 1] = lo;
			end
		end
	endtask : xfer
endmodule : sfp_host_model

// ---- testbench/sfp_pin_if_bench.sv ----
// Purpose: self-checking bench for sfp_pin_if
// Assumes: host model runs mode 0 at a 125 ns link period
// Notes:   expected bytes come from the stimulus, never from the design
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
	$display("FAIL %0t got %h exp %h", $time, (a), (e)); end end
module sfp_pin_if_bench;
	logic       clk_sys, reset, cs_n, sck, hold_low, si_drv, wp_n, busy, so_alt;
	logic       dual_lane_low_out, dual_lane_low_oe, dual_lane_high_out, dual_lane_high_oe;
	logic       rx_valid, tx_dual, tx_valid, tx_ready, frame_active, hold_paused, standby;
	logic       wp_lock;
	logic [7:0] rx_data, tx_data;
	logic [7:0] rxq[$], expq[$];
	int         num_errors, cmp_count;
	integer     seed;
	tri1        hold_n;
	wire        dual_lane_low_in, so_line;
	////////////////////////////////////////
	// A released output line toggles rather than keeps a convenient value; a released hold pulls high
	assign hold_n = hold_low ? 1'h0 : 1'hz;
	assign dual_lane_low_in = dual_lane_low_oe ? dual_lane_low_out : si_drv;
	assign so_line = dual_lane_high_oe ? dual_lane_high_out : so_alt;
	always @(posedge sck) so_alt <= ~so_alt;
	always #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (rx_valid === 1'h1) rxq.push_back(rx_data);
	sfp_pin_if uut (.clk_sys(clk_sys), .reset(reset), .cs_n(cs_n), .sck(sck), .hold_n(hold_n),
		.wp_n(wp_n), .dual_lane_low_in(dual_lane_low_in), .dual_lane_low_out(dual_lane_low_out),
		.dual_lane_low_oe(dual_lane_low_oe), .dual_lane_high_out(dual_lane_high_out),
		.dual_lane_high_oe(dual_lane_high_oe), .rx_data(rx_data), .rx_valid(rx_valid),
		.tx_data(tx_data), .tx_dual(tx_dual), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.busy(busy), .frame_active(frame_active), .hold_paused(hold_paused), .standby(standby),
		.wp_lock(wp_lock));
	sfp_host_model m (.cs_n(cs_n), .sck(sck), .hold_low(hold_low), .si_drv(si_drv),
		.so_line(so_line), .si_line(dual_lane_low_in));
	////////////////////////////////////////
	task automatic wrap_up();
		if (num_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	// Expected status: lock on a low protect pin, standby only deselected and idle
	function automatic logic exp_lock(input logic wp);
		return ~wp;
	endfunction : exp_lock
	function automatic logic exp_standby(input logic cs, input logic bz);
		return cs & ~bz;
	endfunction : exp_standby
	// Received bytes against the sent ones, after the strobe latency
	task automatic check_rx();
		repeat (6) @(posedge clk_sys);
		`CHK(rxq.size(), expq.size())
		foreach (expq[i]) if (i < rxq.size()) `CHK(rxq[i], expq[i])
		rxq.delete();
		expq.delete();
	endtask : check_rx
	// Queue one response byte, waiting a bounded time for room
	task automatic send_tx(input logic [7:0] d, input logic dl);
		int n;
		n = 0;
		@(posedge clk_sys);
		tx_data  <= d;
		tx_dual  <= dl;
		tx_valid <= 1'h1;
		do @(posedge clk_sys); while (tx_ready !== 1'h1 && ++n < 50);
		tx_valid <= 1'h0;
		`CHK(n < 50, 1'h1)
	endtask : send_tx
	////////////////////////////////////////
	initial begin
		#1_000_000;
		num_errors++;
		wrap_up();
	end
	initial begin
		logic [7:0] d;
		logic [7:0] r;
		logic       hi, lo;
		seed = 32'hEF230153;
		{clk_sys, busy, tx_dual, tx_valid, so_alt} = 5'h00;
		{reset, wp_n} = 2'h3;
		tx_data = 8'h00;
		repeat (3) @(posedge clk_sys);
		reset <= 1'h0;
		repeat (5) @(posedge clk_sys);
		`CHK({tx_ready, standby, frame_active, rx_valid}, 4'hC)
		// A stub byte cut by deselect, then noise while deselected
		m.frame_start();
		repeat (3) m.clk_bit(1'($random(seed)), hi, lo);
		m.frame_end();
		repeat (4) m.clk_bit(1'($random(seed)), hi, lo);
		// Random write frames
		repeat (3) begin
			m.frame_start();
			repeat (1 + $unsigned($random(seed)) % 4) begin
				d = $random(seed);
				expq.push_back(d);
				m.xfer(d, 1'h0, r);
			end
			m.frame_end();
			check_rx();
		end
		// Single then dual read after a command byte
		for (int k = 0; k < 2; k++) begin
			d = $random(seed);
			send_tx(d, k[0]);
			m.frame_start();
			r = $random(seed);
			expq.push_back(r);
			m.xfer(r, 1'h0, r);
			if (!k[0]) expq.push_back(8'h5A);
			m.xfer(8'h5A, k[0], r);
			`CHK(r, d)
			m.frame_end();
			`CHK({dual_lane_high_oe, dual_lane_low_oe}, 2'h0)
			check_rx();
		end
		// Pause mid-byte; clocks and data during the pause must not count
		d = $random(seed);
		expq.push_back(d);
		m.frame_start();
		for (int i = 7; i > 4; i--) m.clk_bit(d[i], hi, lo);
		m.hold_low = 1'h1;
		repeat (6) @(posedge clk_sys);
		`CHK({hold_paused, frame_active}, 2'h3)
		repeat (2) m.clk_bit(1'($random(seed)), hi, lo);
		m.hold_low = 1'h0;
		for (int i = 4; i >= 0; i--) m.clk_bit(d[i], hi, lo);
		m.frame_end();
		check_rx();
		`CHK(hold_paused, 1'h0)
		// Write protect and self-timed busy against the status flags
		repeat (6) begin
			d = $random(seed);
			@(posedge clk_sys);
			wp_n <= d[0];
			busy <= d[1];
			repeat (6) @(posedge clk_sys);
			`CHK(wp_lock, exp_lock(d[0]))
			`CHK(standby, exp_standby(cs_n, d[1]))
		end
		wrap_up();
	end
endmodule : sfp_pin_if_bench
